// ===== logic/lsw_pwm.v
`timescale 1ns/10ps
`default_nettype none
`include "lsw_regs.vh"
module lsw_pwm #(
   parameter [7:0] OSC_DIV = 8'h08,
   parameter [7:0] MIN_CYC = 8'h04,
   parameter [7:0] MAX_CYC = 8'h10
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        enable,
   input  wire        clk_sel,
   input  wire        in0_lvl,
   input  wire [27:0] duty_flat,
   input  wire [11:0] delay_flat,
   output reg  [3:0]  wave_q,
   output reg         clk_fail_q
);
   reg  [7:0] div_q;
   reg  [7:0] per_q;
   reg  [6:0] cnt_q;
   reg        in0_d_q;
   integer    i;
   wire       osc_tick = (div_q == OSC_DIV - 8'h01);
   wire       ext_tick = in0_lvl & ~in0_d_q;
   wire       tick     = clk_sel ? osc_tick : ext_tick;
   wire       mon_on   = enable & ~clk_sel;

   // Counter offset by delay*16, then compared with the duty code
   function pwm_bit;
      input [6:0] cnt;
      input [6:0] duty;
      input [2:0] dly;
      reg   [6:0] dcnt;
      begin
         dcnt    = cnt - {dly, 4'h0};
         pwm_bit = (duty == `LSW_DUTY_FULL) | (dcnt <= duty);
      end
   endfunction

   // Shared period counter, clock monitor and channel waveforms
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q      <= 8'h00;
         per_q      <= 8'h00;
         cnt_q      <= 7'h00;
         in0_d_q    <= 1'b0;
         wave_q     <= 4'h0;
         clk_fail_q <= 1'b0;
      end else begin
         in0_d_q <= in0_lvl;
         div_q   <= osc_tick ? 8'h00 : div_q + 8'h01;
         cnt_q   <= !enable ? 7'h00 : (tick ? cnt_q + 7'h01 : cnt_q);
         // Period measured in system cycles between IN0 rising edges
         if (!mon_on) begin
            per_q      <= 8'h00;
            clk_fail_q <= 1'b0;
         end else if (ext_tick) begin
            per_q      <= 8'h00;
            clk_fail_q <= (per_q < MIN_CYC - 8'h01);
         end else if (per_q >= MAX_CYC) begin
            clk_fail_q <= 1'b1;
         end else begin
            per_q <= per_q + 8'h01;
         end
         for (i = 0; i < 4; i = i + 1) begin
            wave_q[i] <= enable & pwm_bit(cnt_q, duty_flat[i*7 +: 7], delay_flat[i*3 +: 3]);
         end
      end
   end
endmodule // lsw_pwm
`default_nettype wire

// ===== logic/lsw_regs.vh
`ifndef LSW_REGS_VH
`define LSW_REGS_VH

// Serial word layout
`define LSW_WORD_BITS      16
`define LSW_WDOG_BIT       15
`define LSW_ADDR_MSB       14
`define LSW_ADDR_LSB       12
`define LSW_DATA_MSB       11

// Register addresses carried in the serial word
`define LSW_ADDR_CTRL      3'h0
`define LSW_ADDR_CHAN0     3'h1
`define LSW_ADDR_CHAN3     3'h4

// Control register fields
`define LSW_CTRL_ON_LSB    0
`define LSW_CTRL_DIS_LSB   4
`define LSW_CTRL_PWM_EN    8
`define LSW_CTRL_CLK_SEL   9
`define LSW_CTRL_VDD_EN    10
`define LSW_CTRL_OV_SEL    11

// Channel register fields
`define LSW_CHAN_DUTY_MSB  6
`define LSW_CHAN_DLY_LSB   7
`define LSW_CHAN_DLY_MSB   9

// Reset values and the full-duty code
`define LSW_CTRL_RST       12'h000
`define LSW_CHAN_RST       10'h000
`define LSW_DUTY_FULL      7'h7F

// Operating mode codes
`define LSW_MODE_SLEEP     2'h0
`define LSW_MODE_NORMAL    2'h1
`define LSW_MODE_FAILSAFE  2'h2
`define LSW_MODE_FAULT     2'h3

// Timing
`define LSW_CLK_PERIOD_NS  40
`define LSW_OSC_PERIOD_NS  320
`define LSW_IN0_MIN_PER_NS 160
`define LSW_IN0_MAX_PER_NS 640

// The same timing as counts of 40 ns system cycles
`define LSW_OSC_DIV        8'h08
`define LSW_IN0_MIN_CYC    8'h04
`define LSW_IN0_MAX_CYC    8'h10

`endif

// ===== logic/lsw_spi.v
`timescale 1ns/10ps
`default_nettype none
module lsw_spi (
   input  wire        clk,
   input  wire        rst,
   input  wire        sclk_pin,
   input  wire        cs_n_pin,
   input  wire        si_pin,
   input  wire [15:0] tx_word,
   output reg  [15:0] rx_word_q,
   output reg         rx_valid_q,
   output reg         so_q,
   output reg         so_oe_q
);
   reg        sclk_s1_q, sclk_s2_q, sclk_s3_q;
   reg        cs_s1_q, cs_s2_q, cs_s3_q;
   reg        si_s1_q, si_s2_q;
   reg [15:0] tx_q;
   reg [15:0] rx_q;
   reg [4:0]  cnt_q;
   wire       sclk_rise = sclk_s2_q & ~sclk_s3_q;
   wire       sclk_fall = ~sclk_s2_q & sclk_s3_q;
   wire       cs_fall   = ~cs_s2_q & cs_s3_q;
   wire       cs_rise   = cs_s2_q & ~cs_s3_q;

   // Pins pass two flops; edges come from the second and third stages
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_s1_q  <= 1'b0;
         sclk_s2_q  <= 1'b0;
         sclk_s3_q  <= 1'b0;
         cs_s1_q    <= 1'b1;
         cs_s2_q    <= 1'b1;
         cs_s3_q    <= 1'b1;
         si_s1_q    <= 1'b0;
         si_s2_q    <= 1'b0;
         tx_q       <= 16'h0000;
         rx_q       <= 16'h0000;
         cnt_q      <= 5'h00;
         rx_word_q  <= 16'h0000;
         rx_valid_q <= 1'b0;
         so_q       <= 1'b0;
         so_oe_q    <= 1'b0;
      end else begin
         sclk_s1_q  <= sclk_pin;
         sclk_s2_q  <= sclk_s1_q;
         sclk_s3_q  <= sclk_s2_q;
         cs_s1_q    <= cs_n_pin;
         cs_s2_q    <= cs_s1_q;
         cs_s3_q    <= cs_s2_q;
         si_s1_q    <= si_pin;
         si_s2_q    <= si_s1_q;
         rx_valid_q <= 1'b0;
         if (cs_fall) begin
            tx_q    <= tx_word;
            cnt_q   <= 5'h00;
            so_oe_q <= 1'b1;
         end else if (cs_rise) begin
            so_oe_q <= 1'b0;
            so_q    <= 1'b0;
            // Only a frame of exactly sixteen bits is taken
            if (cnt_q == 5'h10) begin
               rx_word_q  <= rx_q;
               rx_valid_q <= 1'b1;
            end
         end else if (!cs_s2_q) begin
            if (sclk_rise) begin
               so_q <= tx_q[15];
               tx_q <= {tx_q[14:0], 1'b0};
            end
            if (sclk_fall) begin
               rx_q <= {rx_q[14:0], si_s2_q};
               if (cnt_q != 5'h1F) begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
         end
      end
   end
endmodule // lsw_spi
`default_nettype wire

// ===== logic/lsw_top.v
// How it works
// - Serial output driven only while select low
// - Output shifts on SCLK rise, host samples fall
// - Open strap: watchdog timeout makes outputs follow inputs
// - Grounded strap: only enabled supply fail does
// - Sixteen-bit words, bit fifteen first, both ways
// - Wake is reset or wake or any input
// - Fail from enabled supply fail or watchdog
// - Fault from channel flags, undervoltage, selected overvoltage
// - No wake means sleep, outputs off, config zero
// - Normal mode sets normal flag
// - Fail-safe mode: outputs follow direct inputs
// - Fault mode turns faulted outputs off
// - Output command from inputs, on bits, PWM
// - Fault-reset control from qualified input or on
// - PWM drives output only with enable and on
// - PWM clock from input zero or oscillator
// - Duty is code plus one over 128
// - Other direct inputs ignored under PWM
// - Switching delay is code times sixteen edges
// - Bad external clock flags fault, stops PWM
// - Fail-safe holds configuration at defaults, except the supply-fail enable, which is kept
// - Starts in sleep, returns when all low
// - Serial input sampled on SCLK fall
// - Select rise writes received word to register
// - Select fall loads status for sending
// - Clock and data ignored while select high
`timescale 1ns/10ps
`default_nettype none
`include "lsw_regs.vh"
module lsw_top #(
   // System cycles per oscillator tick, and the accepted external clock
   // period window in system cycles; retune them if the system clock moves
   parameter [7:0] OSC_DIV = `LSW_OSC_DIV,
   parameter [7:0] MIN_CYC = `LSW_IN0_MIN_CYC,
   parameter [7:0] MAX_CYC = `LSW_IN0_MAX_CYC
) (
   input  wire       CLK_SYS,
   input  wire       RST,
   input  wire       SCLK,
   input  wire       CS_N,
   input  wire       SI,
   output wire       SO,
   output wire       SO_OE,
   input  wire [3:0] DIRECT_IN,
   input  wire       WAKE_IN,
   input  wire       RESET_PIN_IN,
   input  wire       WATCHDOG_STRAP_INPUT,
   input  wire       WDOG_TIMEOUT,
   input  wire       VDD_FAIL,
   input  wire [3:0] OVERCURRENT_FLAGS,
   input  wire [3:0] OVERTEMP_FLAGS,
   input  wire [3:0] SHORT_CIRCUIT_FLAGS,
   input  wire       UNDERVOLTAGE_FLAG,
   input  wire       OVERVOLTAGE_FLAG,
   output reg  [3:0] HIGH_SIDE_OUTPUTS,
   output reg  [3:0] FAULT_RESET_CTRL,
   output reg        NORMAL_MODE_FLAG,
   output reg        CLOCK_FAULT_FLAG,
   output reg  [1:0] MODE
);
   // Width of the pin synchroniser bank
   localparam SYNC_W = 23;

   reg  [SYNC_W-1:0] sync1_q;
   reg  [SYNC_W-1:0] sync2_q;
   reg  [11:0]       ctrl_q;
   reg  [9:0]        chan_q [0:3];
   reg  [1:0]        mode_d;
   reg  [3:0]        hs_d;
   reg  [3:0]        frc_d;
   reg  [3:0]        norm_cmd;
   reg  [3:0]        frc_cmd;
   reg  [27:0]       duty_flat;
   reg  [11:0]       delay_flat;
   wire [15:0]       rx_word;
   wire              rx_valid;
   wire [3:0]        pwm_wave;
   wire              clk_fail;
   wire [15:0]       status_word;
   integer           i;
   integer           j;
   integer           k;

   // Synchronised copies of the asynchronous inputs; the strap reads
   // high when open, matching its pull-up
   wire [3:0] din        = sync2_q[3:0];
   wire       wake_pin   = sync2_q[4];
   wire       reset_pin  = sync2_q[5];
   wire       strap_open = sync2_q[6];
   wire       wd_timeout = sync2_q[7];
   wire       vdd_fail   = sync2_q[8];
   wire [3:0] oc_flags   = sync2_q[12:9];
   wire [3:0] ot_flags   = sync2_q[16:13];
   wire [3:0] sc_flags   = sync2_q[20:17];
   wire       uv_flag    = sync2_q[21];
   wire       ov_flag    = sync2_q[22];
   wire       direct_input_zero = din[0];

   // Control fields, decoded once here; all read as zero after sleep, and all but
   // vdd_en after fail-safe, because the store itself is cleared there
   wire [3:0] on_bits  = ctrl_q[`LSW_CTRL_ON_LSB +: 4];
   wire [3:0] dir_dis  = ctrl_q[`LSW_CTRL_DIS_LSB +: 4];
   wire       pwm_en   = ctrl_q[`LSW_CTRL_PWM_EN];
   wire       clk_sel  = ctrl_q[`LSW_CTRL_CLK_SEL];
   wire       vdd_en   = ctrl_q[`LSW_CTRL_VDD_EN];
   wire       overvoltage_fault_select = ctrl_q[`LSW_CTRL_OV_SEL];

   // Mode terms, all from synced levels so a pin that moves near a clock
   // edge cannot split the decode between two modes
   wire [3:0] chan_fault = oc_flags | ot_flags | sc_flags;
   wire       glob_fault = uv_flag | (ov_flag & overvoltage_fault_select);
   wire       wake_term  = reset_pin | wake_pin | (|din);
   wire       fail_term  = (vdd_fail & vdd_en) | (wd_timeout & strap_open);
   wire       fault_term = (|chan_fault) | glob_fault;

   // Writes land only while the mode keeps configuration; a write sent
   // in sleep or fail-safe is lost, not queued
   wire       cfg_live = (mode_d == `LSW_MODE_NORMAL) | (mode_d == `LSW_MODE_FAULT);
   wire [2:0] wr_addr  = rx_word[`LSW_ADDR_MSB:`LSW_ADDR_LSB];
   wire       pwm_run  = pwm_en & cfg_live;
   wire       pwm_live = pwm_run & ~clk_fail;

   // Two flops on every pin before use; the cost is three edges of
   // latency from a pin change to MODE and the outputs, far below
   // anything a lamp or the host can notice
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         sync1_q <= {SYNC_W{1'b0}};
         sync2_q <= {SYNC_W{1'b0}};
      end else begin
         sync1_q <= {OVERVOLTAGE_FLAG, UNDERVOLTAGE_FLAG, SHORT_CIRCUIT_FLAGS,
                     OVERTEMP_FLAGS, OVERCURRENT_FLAGS, VDD_FAIL, WDOG_TIMEOUT,
                     WATCHDOG_STRAP_INPUT, RESET_PIN_IN, WAKE_IN, DIRECT_IN};
         sync2_q <= sync1_q;
      end
   end

   // Mode decode, first match wins: sleep, then fault, then fail-safe,
   // so a fault during fail-safe still switches faulted channels off
   always @* begin
      if (!wake_term) begin
         mode_d = `LSW_MODE_SLEEP;
      end else if (fault_term) begin
         mode_d = `LSW_MODE_FAULT;
      end else if (fail_term) begin
         mode_d = `LSW_MODE_FAILSAFE;
      end else begin
         mode_d = `LSW_MODE_NORMAL;
      end
   end

   // Configuration store; sleep wipes it all, fail-safe all but the
   // supply-fail enable, which must survive or fail-safe would
   // release itself the moment it was entered
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ctrl_q <= `LSW_CTRL_RST;
         for (i = 0; i < 4; i = i + 1) begin
            chan_q[i] <= `LSW_CHAN_RST;
         end
      end else if (mode_d == `LSW_MODE_SLEEP) begin
         ctrl_q <= `LSW_CTRL_RST;
         for (i = 0; i < 4; i = i + 1) begin
            chan_q[i] <= `LSW_CHAN_RST;
         end
      end else if (mode_d == `LSW_MODE_FAILSAFE) begin
         ctrl_q <= `LSW_CTRL_RST | (ctrl_q & (12'h001 << `LSW_CTRL_VDD_EN));
         for (i = 0; i < 4; i = i + 1) begin
            chan_q[i] <= `LSW_CHAN_RST;
         end
      end else if (rx_valid) begin
         if (wr_addr == `LSW_ADDR_CTRL) begin
            ctrl_q <= rx_word[`LSW_DATA_MSB:0];
         end
         for (i = 0; i < 4; i = i + 1) begin
            if (wr_addr == `LSW_ADDR_CHAN0 + i[2:0]) begin
               chan_q[i] <= rx_word[`LSW_CHAN_DLY_MSB:0];
            end
         end
      end
   end

   // Flatten channel settings for the PWM core; each process keeps its
   // own loop index so no combinational block wakes on another's index
   always @* begin
      duty_flat  = 28'h000_0000;
      delay_flat = 12'h000;
      for (j = 0; j < 4; j = j + 1) begin
         duty_flat[j*7 +: 7]  = chan_q[j][`LSW_CHAN_DUTY_MSB:0];
         delay_flat[j*3 +: 3] = chan_q[j][`LSW_CHAN_DLY_MSB:`LSW_CHAN_DLY_LSB];
      end
   end

   // Per-channel command and fault-reset control. A failed external
   // clock falls back to the on bits alone rather than to the direct
   // inputs, since the clock pin itself is then untrustworthy; the
   // fault-reset term keeps the qualified input out while PWM is on
   always @* begin
      norm_cmd = 4'h0;
      frc_cmd  = 4'h0;
      for (k = 0; k < 4; k = k + 1) begin
         if (pwm_live) begin
            norm_cmd[k] = on_bits[k] & pwm_wave[k];
         end else if (pwm_en) begin
            norm_cmd[k] = on_bits[k];
         end else begin
            norm_cmd[k] = (din[k] & ~dir_dis[k]) | on_bits[k];
         end
         frc_cmd[k] = (din[k] & ~dir_dis[k] & ~pwm_en) | on_bits[k];
      end
   end

   // Outputs by mode
   always @* begin
      case (mode_d)
         `LSW_MODE_SLEEP: begin
            hs_d  = 4'h0;
            frc_d = 4'h0;
         end
         `LSW_MODE_NORMAL: begin
            hs_d  = norm_cmd;
            frc_d = frc_cmd;
         end
         `LSW_MODE_FAILSAFE: begin
            hs_d  = din;
            frc_d = frc_cmd;
         end
         `LSW_MODE_FAULT: begin
            // Faulted channels off; autoretry outside re-arms them
            hs_d  = norm_cmd & ~chan_fault & {4{~glob_fault}};
            frc_d = frc_cmd;
         end
         default: begin
            hs_d  = 4'h0;
            frc_d = 4'h0;
         end
      endcase
   end

   // Registered outputs; every top-level pin leaves a flop, so nothing
   // downstream sees the combinational decode settle
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         HIGH_SIDE_OUTPUTS <= 4'h0;
         FAULT_RESET_CTRL  <= 4'h0;
         NORMAL_MODE_FLAG  <= 1'b0;
         CLOCK_FAULT_FLAG  <= 1'b0;
         MODE              <= `LSW_MODE_SLEEP;
      end else begin
         HIGH_SIDE_OUTPUTS <= hs_d;
         FAULT_RESET_CTRL  <= frc_d;
         NORMAL_MODE_FLAG  <= (mode_d == `LSW_MODE_NORMAL);
         CLOCK_FAULT_FLAG  <= clk_fail;
         MODE              <= mode_d;
      end
   end

   // Status word sent on each frame, most significant first. Its upper byte
   // is taken from registered outputs, so the host sees what the pins already
   // show, one edge behind the decode; the lower byte is the synced input flags
   assign status_word = {NORMAL_MODE_FLAG, CLOCK_FAULT_FLAG, MODE, HIGH_SIDE_OUTPUTS,
                         chan_fault, uv_flag, ov_flag, strap_open, wd_timeout};

   // Serial port; its pins are synced inside, so each clock phase of a
   // frame must last at least three system cycles
   lsw_spi u_spi (
      .clk        (CLK_SYS),
      .rst        (RST),
      .sclk_pin   (SCLK),
      .cs_n_pin   (CS_N),
      .si_pin     (SI),
      .tx_word    (status_word),
      .rx_word_q  (rx_word),
      .rx_valid_q (rx_valid),
      .so_q       (SO),
      .so_oe_q    (SO_OE)
   );

   // PWM core; runs only with PWM enabled and configuration live.
   // Dropping the enable zeroes its counter, so every re-entry starts
   // all channels from the same phase
   lsw_pwm #(
      .OSC_DIV (OSC_DIV),
      .MIN_CYC (MIN_CYC),
      .MAX_CYC (MAX_CYC)
   ) u_pwm (
      .clk        (CLK_SYS),
      .rst        (RST),
      .enable     (pwm_run),
      .clk_sel    (clk_sel),
      .in0_lvl    (direct_input_zero),
      .duty_flat  (duty_flat),
      .delay_flat (delay_flat),
      .wave_q     (pwm_wave),
      .clk_fail_q (clk_fail)
   );
endmodule // lsw_top
`default_nettype wire

// ===== tb/lsw_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lsw_host_model (
   input  wire logic clk,
   input  wire logic so,
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic si
);
   // Parked idle: select high, clock and data low
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end
   // One frame, 8-cycle SCLK; SI held across the whole bit
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      integer i;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (i = 15; i >= 0; i = i - 1) begin
         sclk <= 1'b1;
         si   <= w[i];
         repeat (4) @(posedge clk);
         r[i] = so;
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
      end
      cs_n <= 1'b1;
      si   <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule // lsw_host_model
`default_nettype wire

// ===== tb/lsw_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module lsw_top_asserts (
   input wire logic       CLK_SYS,
   input wire logic       RST,
   input wire logic       SCLK,
   input wire logic       CS_N,
   input wire logic       SO,
   input wire logic       SO_OE,
   input wire logic [3:0] DIRECT_IN,
   input wire logic       WAKE_IN,
   input wire logic       RESET_PIN_IN,
   input wire logic       WATCHDOG_STRAP_INPUT,
   input wire logic       WDOG_TIMEOUT,
   input wire logic       VDD_FAIL,
   input wire logic [3:0] OVERCURRENT_FLAGS,
   input wire logic [3:0] OVERTEMP_FLAGS,
   input wire logic [3:0] SHORT_CIRCUIT_FLAGS,
   input wire logic       UNDERVOLTAGE_FLAG,
   input wire logic       OVERVOLTAGE_FLAG,
   input wire logic [3:0] HIGH_SIDE_OUTPUTS,
   input wire logic [3:0] FAULT_RESET_CTRL,
   input wire logic       NORMAL_MODE_FLAG,
   input wire logic [1:0] MODE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // Mode terms seen at the pins; pin sync delay covered by 4-cycle holds
   wire wake_t = WAKE_IN | RESET_PIN_IN | (|DIRECT_IN);
   wire flt_t  = |{OVERCURRENT_FLAGS, OVERTEMP_FLAGS, SHORT_CIRCUIT_FLAGS, UNDERVOLTAGE_FLAG};
   wire ok_t   = wake_t && !flt_t && !OVERVOLTAGE_FLAG;
   sequence s_sel_fall; !SCLK ##0 $fell(CS_N); endsequence
   sequence s_sel_idle; CS_N [*5]; endsequence
   property p_so_idle; s_sel_idle |-> !SO_OE && !SO; endproperty
   property p_so_en; s_sel_fall |-> ##[2:4] SO_OE; endproperty
   property p_so_hold; !CS_N && $fell(SCLK) |=> $stable(SO) [*3]; endproperty
   property p_sleep; (!wake_t) [*4] |=> MODE == 2'h0; endproperty
   property p_sleep_off;
      MODE == 2'h0 |-> HIGH_SIDE_OUTPUTS == 4'h0 && FAULT_RESET_CTRL == 4'h0;
   endproperty
   property p_nm; NORMAL_MODE_FLAG == (MODE == 2'h1); endproperty
   property p_norm; (ok_t && !WDOG_TIMEOUT && !VDD_FAIL) [*4] |=> MODE == 2'h1; endproperty
   property p_fault; (wake_t && flt_t) [*4] |=> MODE == 2'h3; endproperty
   property p_fail;
      (ok_t && WDOG_TIMEOUT && WATCHDOG_STRAP_INPUT) [*4] |=> MODE == 2'h2;
   endproperty
   property p_fs_out;
      (MODE == 2'h2 && $stable(DIRECT_IN)) [*4]
         |-> HIGH_SIDE_OUTPUTS == DIRECT_IN && FAULT_RESET_CTRL == DIRECT_IN;
   endproperty
   a_so_idle: assert property (p_so_idle) else $error("SO driven while deselected");
   a_so_en: assert property (p_so_en) else $error("SO not enabled after select");
   a_so_hold: assert property (p_so_hold) else $error("SO moved near SCLK fall");
   a_sleep: assert property (p_sleep) else $error("No sleep without wake");
   a_sleep_off: assert property (p_sleep_off) else $error("Output on in sleep");
   a_nm: assert property (p_nm) else $error("Normal flag mismatch");
   a_norm: assert property (p_norm) else $error("Normal mode missed");
   a_fault: assert property (p_fault) else $error("Fault mode missed");
   a_fail: assert property (p_fail) else $error("Fail-safe mode missed");
   a_fs_out: assert property (p_fs_out) else $error("Fail-safe outputs wrong");
endmodule // lsw_top_asserts
bind lsw_top lsw_top_asserts u_chk (.*);
`default_nettype wire

// ===== tb/tb_lsw_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_lsw_top;
   logic        clk, rst, wake, rpin, strap, wdog, vdd, uv, ov;
   logic [3:0]  din, oc, ot, sc, hs, frc;
   logic [1:0]  mode;
   logic        sclk, cs_n, si, so, so_oe, nm, cf;
   logic [15:0] rd;
   integer      mismatches, tests_run, k, n0, n2, n3;
   // Status view: {nm, clock fault, mode, outputs, fault-reset controls}
   wire [15:0] st = {4'h0, nm, cf, mode, hs, frc};
   lsw_top #(.OSC_DIV(8'h04), .MIN_CYC(8'h02), .MAX_CYC(8'h10)) uut (
      .CLK_SYS(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so),
      .SO_OE(so_oe), .DIRECT_IN(din), .WAKE_IN(wake), .RESET_PIN_IN(rpin),
      .WATCHDOG_STRAP_INPUT(strap), .WDOG_TIMEOUT(wdog), .VDD_FAIL(vdd),
      .OVERCURRENT_FLAGS(oc), .OVERTEMP_FLAGS(ot), .SHORT_CIRCUIT_FLAGS(sc),
      .UNDERVOLTAGE_FLAG(uv), .OVERVOLTAGE_FLAG(ov), .HIGH_SIDE_OUTPUTS(hs),
      .FAULT_RESET_CTRL(frc), .NORMAL_MODE_FLAG(nm), .CLOCK_FAULT_FLAG(cf),
      .MODE(mode));
   lsw_host_model host (.clk(clk), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));
   // 25 MHz system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Settle just past the edge so registered outputs have landed
   task automatic cyc(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [11:0] d);
      host.xfer({1'b0, a, d}, rd);
      cyc(4);
   endtask
   // Bounded wait for one output to reach a level
   task automatic wait_hs(input integer b, input logic v, output integer n);
      n = 0;
      while (hs[b] !== v && n < 600) begin
         cyc(1);
         n = n + 1;
      end
   endtask
   task end_sim;
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard, far beyond the few thousand cycles the sequence needs
   initial begin
      #800000;
      mismatches = mismatches + 1;
      end_sim;
   end
   initial begin
      tests_run = 0;
      mismatches = 0;
      {rst, strap} = 2'b11;
      {wake, rpin, wdog, vdd, uv, ov} = 6'h00;
      {din, oc, ot, sc} = 16'h0000;
      cyc(11);
      @(posedge clk) rst <= 1'b0;
      cyc(4);
      chk(st, 16'h0000);
      @(posedge clk) rpin <= 1'b1;
      cyc(6);
      chk(st, 16'h0900);
      @(posedge clk) din <= 4'h5;
      cyc(6);
      chk(st, 16'h0955);
      wr(3'h0, 12'h052);
      chk(st, 16'h0922);
      wr(3'h0, 12'h002);
      chk(rd, 16'h9202);
      chk(st, 16'h0977);
      // Each fault source in turn: channel flags on lane 1, then undervoltage
      for (k = 0; k < 4; k = k + 1) begin
         @(posedge clk) {uv, sc, ot, oc} <= (k == 3) ? 13'h1000 : (13'h0002 << (4 * k));
         cyc(6);
         chk({8'h00, st[11:4]}, (k == 3) ? 16'h0030 : 16'h0035);
         @(posedge clk) {uv, sc, ot, oc} <= 13'h0000;
         cyc(6);
      end
      // Overvoltage is a fault only with its select bit set
      @(posedge clk) ov <= 1'b1;
      cyc(6);
      chk(st, 16'h0977);
      wr(3'h0, 12'h802);
      chk({8'h00, st[11:4]}, 16'h0030);
      @(posedge clk) ov <= 1'b0;
      cyc(6);
      @(posedge clk) wdog <= 1'b1;
      cyc(6);
      chk(st, 16'h0255);
      wr(3'h0, 12'h00F);
      @(posedge clk) wdog <= 1'b0;
      cyc(6);
      chk(st, 16'h0955);
      @(posedge clk) {strap, wdog, vdd} <= 3'b011;
      cyc(6);
      chk(st, 16'h0955);
      wr(3'h0, 12'h400);
      chk(st, 16'h0255);
      @(posedge clk) {strap, wdog, vdd, din} <= 7'h4E;
      cyc(6);
      wr(3'h1, 12'h01F);
      wr(3'h2, 12'h09F);
      wr(3'h4, 12'h07F);
      wr(3'h0, 12'h30B);
      {n0, n2, n3} = 96'h0;
      // One full PWM period of 128 oscillator ticks, 4 cycles each
      repeat (512) begin
         cyc(1);
         n0 = n0 + hs[0];
         n2 = n2 + hs[2];
         n3 = n3 + hs[3];
      end
      chk(n0[15:0], 16'd128);
      chk(n2[15:0], 16'd0);
      chk(n3[15:0], 16'd512);
      wait_hs(0, 1'b0, n0);
      wait_hs(0, 1'b1, n0);
      wait_hs(1, 1'b1, n0);
      chk(n0[15:0], 16'd64);
      wr(3'h0, 12'h103);
      cyc(40);
      chk({11'h000, cf, hs}, 16'h0013);
      repeat (32) begin
         @(posedge clk) din[0] <= ~din[0];
         repeat (3) @(posedge clk);
      end
      cyc(2);
      chk({15'h0000, cf}, 16'h0000);
      @(posedge clk) {rpin, din} <= 5'h00;
      cyc(8);
      chk(st, 16'h0000);
      // The wake pin alone brings the block up in normal mode
      @(posedge clk) wake <= 1'b1;
      cyc(6);
      chk(st, 16'h0900);
      end_sim;
   end
endmodule // tb_lsw_top
`default_nettype wire
